// ---- moe_exec.sv ----
// Functional notes
// - Store writes working register to effective location; register unchanged.
// - Store_zero_word, opcode 14, writes zero word; register unchanged.
// - Twos_complement_add, opcode 34, adds memory; carry out complements carry bit.
// - Ones-complement add, opcode 30, end-around; like-sign overflow sets carry, sticky.
// - Increment_skip_zero, opcode 44, writes incremented word back; skips if zero.
// - Skip_if_differ, opcode 54, skips when memory differs from register.
// - AND, opcode 50, bitwise ANDs memory into working register.
// - XOR, opcode 24, bitwise exclusive-ORs memory into working register.
// - Execute_remote, opcode 40, runs instruction at effective address.
// - In user mode, execute_remote targeting execute_remote is refused.
// - Jump, opcode 60, loads operand bits 5-17 into program counter.
// - Jump_subroutine saves carry, bank, user, PC; continues at target plus one.
// - Outside user mode, interrupts blocked for one instruction after jump_subroutine.
// - Memory-management variant with user mode stores only the 15-bit PC instead, upper three bits zero.
// - Supervisor_entry saves state at 20, clears user mode, continues at 21.
// - Supervisor_entry raises priority 4 if enabled and the current level is below 4; blocks interrupts one instruction.
// - Operate instructions finish in one cycle; bits combine, except a rotate or swap disables switch-OR and complements.
// - Operate bits: clears, rotate-two, invert, skips, halt, rotates, OR, complements.
// - Bits 13,14 give increment_working, with bit 7 swap_halves, not rotation.
// - Non-inverted skips are ORed: carry set, register zero, register negative.
// - Inverted skips are ANDed: carry clear, register nonzero, non-negative.
// - Operate order: skips, clears, rotates, complements and switch-OR, halt last.
// - Increment_working overflow complements the carry bit.

`timescale 1ns/1ps
`default_nettype none

module moe_exec #(
   parameter int unsigned ADDR_W = moe_pkg::ADDR_W
) (
   // Clock and reset
   input  wire logic                 core_clk_i,
   input  wire logic                 rst_n_i,
   // Core memory
   output wire moe_pkg::moe_mem_req_t mem_o,
   input  wire logic                 mem_ack_i,
   input  wire logic [17:0]          mem_rdata_i,
   // Mode and console inputs
   input  wire logic                 run_i,
   input  wire logic                 mm_variant_i,
   input  wire logic                 irq_enable_i,
   input  wire logic [17:0]          switches_i,
   input  wire logic [2:0]           irq_level_i,
   // State outputs
   output logic [17:0]               working_register_o,
   output logic                      carry_o,
   output logic [14:0]               pc_o,
   output logic                      bank_addressing_mode_o,
   output logic                      user_protection_mode_o,
   output logic                      halted_o,
   output logic                      irq_block_o,
   output logic                      raise_prio_o,
   output logic [2:0]                raise_level_o,
   output logic                      xct_trap_o
);

   if (ADDR_W != 15) begin : g_addr_check
      $error("moe_exec supports a 15-bit address only");
   end

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   moe_pkg::moe_state_t state_q, state_d;
   logic [17:0] ac_q, ac_d;
   logic        link_q, link_d;
   logic [14:0] pc_q, pc_d;
   logic        um_q, um_d;
   logic        bm_q;
   logic [17:0] ir_q, ir_d;
   logic        xct_q, xct_d;
   logic        blk_q, blk_d;
   logic        rp_q, rp_d;
   logic        trap_q, trap_d;
   logic [14:0] ea_q, ea_d;
   logic [17:0] wd_q, wd_d;
   moe_pkg::moe_op_dec_t dec;

   // ------------------------------------------------------------
   // Decode and datapath
   // ------------------------------------------------------------
   wire logic [3:0]  opc      = ir_q[17:14];
   wire logic [14:0] ea_now   = {2'h0, ir_q[12:0]};
   wire logic [18:0] tsum     = {1'b0, ac_q} + {1'b0, mem_rdata_i};
   wire logic [18:0] osum_raw = {1'b0, ac_q} + {1'b0, mem_rdata_i};
   wire logic [17:0] osum     = osum_raw[17:0] + {17'h0, osum_raw[18]};
   wire logic        ovf      = (ac_q[17] == mem_rdata_i[17]) && (osum[17] != ac_q[17]);
   wire logic [17:0] inc_word = mem_rdata_i + 18'h00001;
   wire logic [14:0] pc_skip  = pc_q + 15'h0001;
   wire logic [17:0] jms_word = (mm_variant_i && um_q) ? {3'h0, pc_q} : {link_q, bm_q, um_q, pc_q};
   wire logic        needs_rd = (opc == moe_pkg::OP_LOAD) || (opc == moe_pkg::OP_XOR) ||
                                (opc == moe_pkg::OP_ONES_ADD) || (opc == moe_pkg::OP_TWOS_ADD) ||
                                (opc == moe_pkg::OP_INC_SKIP) || (opc == moe_pkg::OP_AND) ||
                                (opc == moe_pkg::OP_SKIP_DIFFER) || (opc == moe_pkg::OP_EXEC_REMOTE);

   moe_operate_dec u_dec (
      .op_word_i (ir_q),
      .carry_i   (link_q),
      .work_i    (ac_q),
      .dec_o     (dec)
   );

   // Operate datapath in column order: clears, then rotates, complements and switch-OR.
   logic [17:0] op_ac;
   logic        op_l;
   always_comb begin
      op_ac = ir_q[moe_pkg::OPB_CLR_WORK] ? moe_pkg::WORD_ZERO : ac_q;
      op_l  = ir_q[moe_pkg::OPB_CLR_CARRY] ? 1'b0 : link_q;
      if (dec.swap) begin
         op_ac = {op_ac[8:0], op_ac[17:9]};
      end else if (dec.rot_right) begin
         {op_ac, op_l} = dec.rot_two ? {op_ac[0], op_l, op_ac[17:1]} : {op_l, op_ac};
      end else if (dec.rot_left) begin
         {op_l, op_ac} = dec.rot_two ? {op_ac[16:0], op_l, op_ac[17]} : {op_ac, op_l};
      end else begin
         if (ir_q[moe_pkg::OPB_OR_SWITCH]) op_ac = op_ac | switches_i;
         if (ir_q[moe_pkg::OPB_CMP_WORK])  op_ac = ~op_ac;
         if (dec.inc_work) begin
            if (op_ac == 18'h3ffff) op_l = ~op_l;
            op_ac = op_ac + 18'h00001;
         end
         if (ir_q[moe_pkg::OPB_CMP_CARRY]) op_l = ~op_l;
      end
   end

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      ac_d = ac_q;
      link_d = link_q;
      pc_d = pc_q;
      um_d = um_q;
      ir_d = ir_q;
      xct_d = xct_q;
      blk_d = blk_q;
      rp_d = 1'b0;
      trap_d = 1'b0;
      ea_d = ea_q;
      wd_d = wd_q;
      case (state_q)
         moe_pkg::MOE_FETCH: begin
            if (run_i) state_d = moe_pkg::MOE_FETCH_WAIT;
         end
         moe_pkg::MOE_FETCH_WAIT: begin
            if (mem_ack_i) begin
               ir_d = mem_rdata_i;
               if (!xct_q) pc_d = pc_q + 15'h0001;
               state_d = moe_pkg::MOE_OPERAND;
            end
         end
         moe_pkg::MOE_OPERAND: begin
            state_d = moe_pkg::MOE_FETCH;
            xct_d = 1'b0;
            blk_d = 1'b0;
            ea_d = ea_now;
            case (opc)
               moe_pkg::OP_STORE: begin
                  wd_d = ac_q;
                  state_d = moe_pkg::MOE_WRITE;
               end
               moe_pkg::OP_STORE_ZERO: begin
                  wd_d = moe_pkg::WORD_ZERO;
                  state_d = moe_pkg::MOE_WRITE;
               end
               moe_pkg::OP_JUMP: pc_d = ea_now;
               moe_pkg::OP_JUMP_SUB: begin
                  wd_d = jms_word;
                  pc_d = ea_now + 15'h0001;
                  blk_d = !um_q;
                  state_d = moe_pkg::MOE_WRITE;
               end
               moe_pkg::OP_SUPERVISOR: begin
                  ea_d = moe_pkg::SUPER_SAVE_ADDR;
                  wd_d = jms_word;
                  pc_d = moe_pkg::SUPER_ENTRY_ADDR;
                  um_d = 1'b0;
                  blk_d = 1'b1;
                  rp_d = irq_enable_i && (irq_level_i < moe_pkg::SUPER_PRIO_LVL);
                  state_d = moe_pkg::MOE_WRITE;
               end
               moe_pkg::OP_OPERATE: begin
                  ac_d = op_ac;
                  link_d = op_l;
                  if (dec.skip) pc_d = pc_skip;
                  if (ir_q[moe_pkg::OPB_HALT]) state_d = moe_pkg::MOE_HALTED;
               end
               default: begin
                  if (needs_rd) state_d = moe_pkg::MOE_OPERAND_WAIT;
               end
            endcase
         end
         moe_pkg::MOE_OPERAND_WAIT: begin
            if (mem_ack_i) begin
               state_d = moe_pkg::MOE_FETCH;
               case (opc)
                  moe_pkg::OP_LOAD: ac_d = mem_rdata_i;
                  moe_pkg::OP_TWOS_ADD: begin
                     ac_d = tsum[17:0];
                     link_d = link_q ^ tsum[18];
                  end
                  moe_pkg::OP_ONES_ADD: begin
                     ac_d = osum;
                     link_d = link_q | ovf;
                  end
                  moe_pkg::OP_AND: ac_d = ac_q & mem_rdata_i;
                  moe_pkg::OP_XOR: ac_d = ac_q ^ mem_rdata_i;
                  moe_pkg::OP_SKIP_DIFFER: begin
                     if (mem_rdata_i != ac_q) pc_d = pc_skip;
                  end
                  moe_pkg::OP_INC_SKIP: begin
                     wd_d = inc_word;
                     if (inc_word == moe_pkg::WORD_ZERO) pc_d = pc_skip;
                     state_d = moe_pkg::MOE_WRITE;
                  end
                  moe_pkg::OP_EXEC_REMOTE: begin
                     if (um_q && (mem_rdata_i[17:14] == moe_pkg::OP_EXEC_REMOTE)) begin
                        trap_d = 1'b1;
                     end else begin
                        ir_d = mem_rdata_i;
                        xct_d = 1'b1;
                        state_d = moe_pkg::MOE_OPERAND;
                     end
                  end
                  default: ;
               endcase
            end
         end
         moe_pkg::MOE_WRITE: state_d = moe_pkg::MOE_WRITE_WAIT;
         moe_pkg::MOE_WRITE_WAIT: begin
            if (mem_ack_i) state_d = moe_pkg::MOE_FETCH;
         end
         moe_pkg::MOE_HALTED: begin
            if (!run_i) state_d = moe_pkg::MOE_FETCH;
         end
         default: state_d = moe_pkg::MOE_FETCH;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         state_q <= moe_pkg::MOE_FETCH;
         ac_q <= moe_pkg::WORD_ZERO;
         link_q <= 1'b0;
         pc_q <= moe_pkg::PC_RESET;
         um_q <= 1'b0;
         bm_q <= 1'b0;
         ir_q <= moe_pkg::WORD_ZERO;
         xct_q <= 1'b0;
         blk_q <= 1'b0;
         rp_q <= 1'b0;
         trap_q <= 1'b0;
         ea_q <= moe_pkg::PC_RESET;
         wd_q <= moe_pkg::WORD_ZERO;
      end else begin
         state_q <= state_d;
         ac_q <= ac_d;
         link_q <= link_d;
         pc_q <= pc_d;
         um_q <= um_d;
         ir_q <= ir_d;
         xct_q <= xct_d;
         blk_q <= blk_d;
         rp_q <= rp_d;
         trap_q <= trap_d;
         ea_q <= ea_d;
         wd_q <= wd_d;
      end
   end

   // ------------------------------------------------------------
   // Memory request and outputs
   // ------------------------------------------------------------
   // Fetches use the program counter; in execute_remote the next fetch resumes normally.
   assign mem_o.req   = (state_q == moe_pkg::MOE_FETCH_WAIT) || (state_q == moe_pkg::MOE_OPERAND_WAIT) ||
                        (state_q == moe_pkg::MOE_WRITE_WAIT);
   assign mem_o.wr    = (state_q == moe_pkg::MOE_WRITE_WAIT);
   assign mem_o.addr  = (state_q == moe_pkg::MOE_FETCH_WAIT) ? pc_q :
                        (state_q == moe_pkg::MOE_OPERAND_WAIT) ? ea_now : ea_q;
   assign mem_o.wdata = wd_q;

   assign working_register_o     = ac_q;
   assign carry_o                = link_q;
   assign pc_o                   = pc_q;
   assign bank_addressing_mode_o = bm_q;
   assign user_protection_mode_o = um_q;
   assign halted_o               = (state_q == moe_pkg::MOE_HALTED);
   assign irq_block_o            = blk_q;
   assign raise_prio_o           = rp_q;
   assign raise_level_o          = moe_pkg::SUPER_PRIO_LVL;
   assign xct_trap_o             = trap_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_supv;
      state_q == moe_pkg::MOE_OPERAND && opc == moe_pkg::OP_SUPERVISOR;
   endsequence

   AST_SUPV_ENTRY: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      s_supv |=> (pc_q == moe_pkg::SUPER_ENTRY_ADDR) && !um_q && (ea_q == moe_pkg::SUPER_SAVE_ADDR))
      else $error("supervisor entry did not vector to 21");
   AST_JUMP: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (state_q == moe_pkg::MOE_OPERAND && opc == moe_pkg::OP_JUMP) |=> pc_q == $past(ea_now))
      else $error("jump target wrong");
   AST_STORE_ZERO: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (state_q == moe_pkg::MOE_OPERAND && opc == moe_pkg::OP_STORE_ZERO) |=> ##1 mem_o.wr && mem_o.wdata == 18'h0)
      else $error("store zero wrote nonzero");
   AST_STORE_KEEPS_AC: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (state_q == moe_pkg::MOE_OPERAND && opc == moe_pkg::OP_STORE) |=> wd_q == $past(ac_q) && $stable(ac_q))
      else $error("store changed register or wrote wrong data");
   AST_JMS_BLOCK: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (state_q == moe_pkg::MOE_OPERAND && opc == moe_pkg::OP_JUMP_SUB && !um_q) |=> irq_block_o)
      else $error("no interrupt block after subroutine jump");
   AST_RMW_BEFORE_FETCH: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (state_q == moe_pkg::MOE_WRITE_WAIT && !mem_ack_i) |=> state_q == moe_pkg::MOE_WRITE_WAIT)
      else $error("fetch began before write completed");
   AST_OPERATE_ONE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (state_q == moe_pkg::MOE_OPERAND && opc == moe_pkg::OP_OPERATE && !ir_q[moe_pkg::OPB_HALT])
      |=> state_q == moe_pkg::MOE_FETCH)
      else $error("operate took more than one cycle");
   AST_XCT_TRAP: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (state_q == moe_pkg::MOE_OPERAND_WAIT && mem_ack_i && opc == moe_pkg::OP_EXEC_REMOTE && um_q &&
       mem_rdata_i[17:14] == moe_pkg::OP_EXEC_REMOTE) |=> xct_trap_o && state_q == moe_pkg::MOE_FETCH)
      else $error("nested execute_remote allowed in user mode");
   AST_JMS_SAVE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (state_q == moe_pkg::MOE_OPERAND && opc == moe_pkg::OP_JUMP_SUB)
      |=> (ea_q == $past(ea_now)) && (pc_q == 15'($past(ea_now) + 15'h0001)) && (wd_q[14:0] == $past(pc_q)))
      else $error("subroutine jump saved or resumed wrongly");
   AST_TWOS_SUM: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (state_q == moe_pkg::MOE_OPERAND_WAIT && mem_ack_i && opc == moe_pkg::OP_TWOS_ADD)
      |=> ac_q == 18'($past(ac_q) + $past(mem_rdata_i)))
      else $error("twos complement sum wrong");
   AST_SKIP_ONE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (state_q == moe_pkg::MOE_OPERAND && opc == moe_pkg::OP_OPERATE && dec.skip)
      |=> pc_q == 15'($past(pc_q) + 15'h0001))
      else $error("operate skip did not bypass exactly one word");
   AST_HALT_LAST: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (state_q == moe_pkg::MOE_OPERAND && opc == moe_pkg::OP_OPERATE && ir_q[moe_pkg::OPB_HALT]) |=> halted_o)
      else $error("halt bit did not stop the sequencer");

endmodule

`default_nettype wire

// ---- moe_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module moe_mem_model (
   // Clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  rst_n_i,
   // Request and answer
   input  wire moe_pkg::moe_mem_req_t req_i,
   input  wire logic [3:0]            lat_i,
   output logic                       ack_o,
   output logic [17:0]                rdata_o
);
   logic [17:0] mem [0:32767];
   logic [3:0]  cnt_q;

   // Outside its ack cycle the data bus inverts its word every cycle, so a sample one cycle late cannot match by luck.
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         ack_o   <= 1'b0;
         cnt_q   <= 4'h0;
         rdata_o <= 18'h2aaaa;
      end else if (req_i.req && !ack_o && cnt_q >= lat_i) begin
         ack_o   <= 1'b1;
         cnt_q   <= 4'h0;
         rdata_o <= req_i.wr ? ~rdata_o : mem[req_i.addr];
         if (req_i.wr) begin
            mem[req_i.addr] <= req_i.wdata;
         end
      end else begin
         ack_o   <= 1'b0;
         cnt_q   <= (req_i.req && !ack_o) ? cnt_q + 4'h1 : 4'h0;
         rdata_o <= ~rdata_o;
      end
   end
endmodule

`default_nettype wire

// ---- moe_operate_dec.sv ----
`timescale 1ns/1ps
`default_nettype none

module moe_operate_dec (
   // Operate word and current state
   input  wire logic [17:0]        op_word_i,
   input  wire logic               carry_i,
   input  wire logic [17:0]        work_i,
   // Decoded actions
   output wire moe_pkg::moe_op_dec_t dec_o
);

   wire logic inv_sense;
   wire logic cond_carry;
   wire logic cond_zero;
   wire logic cond_neg;
   wire logic any_sel;
   wire logic both_rot;

   assign inv_sense  = op_word_i[moe_pkg::OPB_INVERT];
   assign cond_carry = op_word_i[moe_pkg::OPB_SK_CARRY] & carry_i;
   assign cond_zero  = op_word_i[moe_pkg::OPB_SK_ZERO] & (work_i == moe_pkg::WORD_ZERO);
   assign cond_neg   = op_word_i[moe_pkg::OPB_SK_NEG] & work_i[17];
   assign any_sel    = |op_word_i[moe_pkg::OPB_SK_CARRY -: 3];
   assign both_rot   = op_word_i[moe_pkg::OPB_ROT_RIGHT] & op_word_i[moe_pkg::OPB_ROT_LEFT];

   // With the inverted sense every selected condition must fail; with no selection this is skip_always.
   assign dec_o.skip = inv_sense ?
      !((op_word_i[moe_pkg::OPB_SK_CARRY] & carry_i) |
        (op_word_i[moe_pkg::OPB_SK_ZERO] & (work_i == moe_pkg::WORD_ZERO)) |
        (op_word_i[moe_pkg::OPB_SK_NEG] & work_i[17])) :
      (cond_carry | cond_zero | cond_neg);
   assign dec_o.inc_work  = both_rot & !op_word_i[moe_pkg::OPB_ROT_TWO];
   assign dec_o.swap      = both_rot & op_word_i[moe_pkg::OPB_ROT_TWO];
   assign dec_o.rot_right = op_word_i[moe_pkg::OPB_ROT_RIGHT] & !both_rot;
   assign dec_o.rot_left  = op_word_i[moe_pkg::OPB_ROT_LEFT] & !both_rot;
   assign dec_o.rot_two   = op_word_i[moe_pkg::OPB_ROT_TWO];

   wire logic unused_sel;
   assign unused_sel = any_sel;

endmodule

`default_nettype wire

// ---- moe_pkg.sv ----
package moe_pkg;

   // ------------------------------------------------------------
   // Word layout
   // ------------------------------------------------------------
   localparam int unsigned WORD_W = 18;
   localparam int unsigned ADDR_W = 15;

   // Opcodes sit in instruction bits 0-3, which are the top four bits of the word.
   localparam logic [3:0] OP_SUPERVISOR   = 4'h0;
   localparam logic [3:0] OP_STORE        = 4'h1;
   localparam logic [3:0] OP_JUMP_SUB     = 4'h2;
   localparam logic [3:0] OP_STORE_ZERO   = 4'h3;
   localparam logic [3:0] OP_LOAD         = 4'h4;
   localparam logic [3:0] OP_XOR          = 4'h5;
   localparam logic [3:0] OP_ONES_ADD     = 4'h6;
   localparam logic [3:0] OP_TWOS_ADD     = 4'h7;
   localparam logic [3:0] OP_EXEC_REMOTE  = 4'h8;
   localparam logic [3:0] OP_INC_SKIP     = 4'h9;
   localparam logic [3:0] OP_AND          = 4'ha;
   localparam logic [3:0] OP_SKIP_DIFFER  = 4'hb;
   localparam logic [3:0] OP_JUMP         = 4'hc;
   localparam logic [3:0] OP_OPERATE      = 4'hf;

   // Operate word bit positions, written as vector indices (index = 17 - bit number).
   localparam int unsigned OPB_CLR_WORK   = 12;
   localparam int unsigned OPB_CLR_CARRY  = 11;
   localparam int unsigned OPB_ROT_TWO    = 10;
   localparam int unsigned OPB_INVERT     = 9;
   localparam int unsigned OPB_SK_CARRY   = 8;
   localparam int unsigned OPB_SK_ZERO    = 7;
   localparam int unsigned OPB_SK_NEG     = 6;
   localparam int unsigned OPB_HALT       = 5;
   localparam int unsigned OPB_ROT_RIGHT  = 4;
   localparam int unsigned OPB_ROT_LEFT   = 3;
   localparam int unsigned OPB_OR_SWITCH  = 2;
   localparam int unsigned OPB_CMP_CARRY  = 1;
   localparam int unsigned OPB_CMP_WORK   = 0;

   // ------------------------------------------------------------
   // Fixed locations, priority and reset values
   // ------------------------------------------------------------
   localparam logic [14:0] SUPER_SAVE_ADDR = 15'h0010;
   localparam logic [14:0] SUPER_ENTRY_ADDR = 15'h0011;
   localparam logic [2:0]  SUPER_PRIO_LVL = 3'h4;
   localparam logic [14:0] PC_RESET       = 15'h0000;
   localparam logic [17:0] WORD_ZERO      = 18'h00000;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic        req;
      logic        wr;
      logic [14:0] addr;
      logic [17:0] wdata;
   } moe_mem_req_t;

   typedef struct packed {
      logic        rot_right;
      logic        rot_left;
      logic        rot_two;
      logic        inc_work;
      logic        swap;
      logic        skip;
   } moe_op_dec_t;

   typedef enum logic [2:0] {
      MOE_FETCH,
      MOE_FETCH_WAIT,
      MOE_OPERAND,
      MOE_OPERAND_WAIT,
      MOE_WRITE,
      MOE_WRITE_WAIT,
      MOE_HALTED
   } moe_state_t;

endpackage

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench;
   typedef struct {
      logic [17:0] ins, a, b, ac;
      logic        c;
      logic [14:0] chk;
      logic [17:0] mv;
      logic [14:0] pc;
   } moe_row_t;

   logic                  clk = 1'b0;
   logic                  rst_n = 1'b0;
   logic                  run = 1'b0;
   logic [3:0]            lat = 4'h0;
   logic                  ack, carry, um, halted, prio, prio_seen;
   logic [17:0]           rdata, ac;
   logic [14:0]           pc;
   logic [2:0]            lvl;
   moe_pkg::moe_mem_req_t mem_req;
   moe_row_t              rows [0:19];
   int                    error_cnt = 0;
   int                    n_checks = 0;

   always #2 clk = ~clk;

   moe_exec dut (.core_clk_i(clk), .rst_n_i(rst_n), .mem_o(mem_req), .mem_ack_i(ack), .mem_rdata_i(rdata),
      .run_i(run), .mm_variant_i(1'b0), .irq_enable_i(1'b1), .switches_i(18'h2a5a5), .irq_level_i(3'h0),
      .working_register_o(ac), .carry_o(carry), .pc_o(pc), .bank_addressing_mode_o(),
      .user_protection_mode_o(um), .halted_o(halted), .irq_block_o(), .raise_prio_o(prio),
      .raise_level_o(lvl), .xct_trap_o());

   moe_mem_model u_mem (.clk_i(clk), .rst_n_i(rst_n), .req_i(mem_req), .lat_i(lat), .ack_o(ack), .rdata_o(rdata));

   always @(posedge clk) if (prio === 1'b1 && lvl === moe_pkg::SUPER_PRIO_LVL) prio_seen <= 1'b1;

   function automatic logic [17:0] mr(input logic [3:0] op);
      return {op, 14'h0101};
   endfunction

   task automatic check(input logic [17:0] got, input logic [17:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic give_verdict();
      $display("Checks %0d, errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Every word but the two program words and the two data words is a halt, so a program stops at the first word it was not meant to run.
   task automatic run_prog(input moe_row_t r);
      int i;
      for (i = 0; i < 32768; i++) u_mem.mem[i] = 18'h3c020;
      u_mem.mem[0] = {moe_pkg::OP_LOAD, 14'h0100};
      u_mem.mem[1] = r.ins;
      u_mem.mem[15'h100] = r.a;
      u_mem.mem[15'h101] = r.b;
      rst_n = 1'b0;
      run = 1'b0;
      prio_seen = 1'b0;
      repeat (6) @(posedge clk);
      #1 rst_n = 1'b1;
      run = 1'b1;
      i = 0;
      while (halted !== 1'b1 && i < 400) begin
         @(posedge clk);
         i++;
      end
      #1 check(18'(halted), 18'h1);
      check(ac, r.ac);
      check(18'(carry), 18'(r.c));
      check(u_mem.mem[r.chk], r.mv);
      check(18'(pc), 18'(r.pc));
   endtask

   initial begin
      rows = '{
         '{mr(4'h1), 18'h12345, 18'h3ffff, 18'h12345, 1'b0, 15'h101, 18'h12345, 15'h3},
         '{mr(4'h3), 18'h12345, 18'h3ffff, 18'h12345, 1'b0, 15'h101, 18'h00000, 15'h3},
         '{mr(4'h7), 18'h3ffff, 18'h00002, 18'h00001, 1'b1, 15'h101, 18'h00002, 15'h3},
         '{mr(4'h6), 18'h1ffff, 18'h00001, 18'h20000, 1'b1, 15'h101, 18'h00001, 15'h3},
         '{mr(4'h6), 18'h3fffe, 18'h00005, 18'h00004, 1'b0, 15'h101, 18'h00005, 15'h3},
         '{mr(4'h9), 18'h00007, 18'h3ffff, 18'h00007, 1'b0, 15'h101, 18'h00000, 15'h4},
         '{mr(4'h9), 18'h00007, 18'h00005, 18'h00007, 1'b0, 15'h101, 18'h00006, 15'h3},
         '{mr(4'hb), 18'h00005, 18'h00005, 18'h00005, 1'b0, 15'h101, 18'h00005, 15'h3},
         '{mr(4'hb), 18'h00005, 18'h00004, 18'h00005, 1'b0, 15'h101, 18'h00004, 15'h4},
         '{mr(4'ha), 18'h0ff0f, 18'h3f0f0, 18'h0f000, 1'b0, 15'h101, 18'h3f0f0, 15'h3},
         '{mr(4'h5), 18'h0ff0f, 18'h3f0f0, 18'h30fff, 1'b0, 15'h101, 18'h3f0f0, 15'h3},
         '{mr(4'h8), 18'h00000, 18'h3c080, 18'h00000, 1'b0, 15'h101, 18'h3c080, 15'h4},
         '{18'h30040, 18'h00005, 18'h00000, 18'h00005, 1'b0, 15'h101, 18'h00000, 15'h41},
         '{18'h08030, 18'h00005, 18'h00000, 18'h00005, 1'b0, 15'h030, 18'h00002, 15'h32},
         '{18'h3c2c0, 18'h00005, 18'h00000, 18'h00005, 1'b0, 15'h101, 18'h00000, 15'h4},
         '{18'h3c018, 18'h3ffff, 18'h00000, 18'h00000, 1'b1, 15'h101, 18'h00000, 15'h3},
         '{18'h3c418, 18'h001ff, 18'h00000, 18'h3fe00, 1'b0, 15'h101, 18'h00000, 15'h3},
         '{18'h3d004, 18'h12345, 18'h00000, 18'h2a5a5, 1'b0, 15'h101, 18'h00000, 15'h3},
         '{18'h3c8c1, 18'h2f0f0, 18'h00000, 18'h10f0f, 1'b0, 15'h101, 18'h00000, 15'h4},
         '{18'h00000, 18'h00005, 18'h00000, 18'h00005, 1'b0, 15'h010, 18'h00002, 15'h12}};
      repeat (6) @(posedge clk);
      #1 check(ac, 18'h0);
      check(18'(pc), 18'(moe_pkg::PC_RESET));
      check(18'(mem_req.req), 18'h0);
      // A slow memory run repeats every case with the partner stalling each transfer.
      for (int d = 0; d < 2; d++) begin
         lat = d ? 4'h3 : 4'h0;
         foreach (rows[k]) run_prog(rows[k]);
      end
      check(18'(prio_seen), 18'h1);
      check(18'(um), 18'h0);
      give_verdict();
   end

   initial begin
      #200000;
      error_cnt++;
      give_verdict();
   end
endmodule

`default_nettype wire
